// ### src/qrt_timer_unit.sv
`timescale 1ns/100ps
// Contract
// RULE_01 - Four independent 16-bit programmable counters
// RULE_02 - Each has counter, input latch, output latch
// RULE_03 - Counters decrement every reference clock over four
// RULE_04 - Underflow reloads from latch, raises channel event
// RULE_05 - Zero reload value keeps counter at zero
// RULE_06 - Trigger colliding with underflow costs one tick
// RULE_07 - Low and high byte writes form reload
// RULE_08 - Trigger write loads counter from latch immediately
// RULE_09 - Snapshot write copies counter to output latch
// RULE_10 - Count reads return output latch bytes
// RULE_11 - Channel 0/1 underflow sets its flag
// RULE_12 - Flags latch until ones written to clear
// RULE_13 - Software picks interval reload values
// RULE_14 - Channel 2 drives rate clock pin
// RULE_15 - Channel 3 sets keyboard link rate
// RULE_16 - Software programs channels before trusting values
// RULE_17 - Keyboard link samples at channel 3 rate
// RULE_18 - Rate pin toggles on every channel 2 underflow
// RULE_19 - Output latch holds until next snapshot
module qrt_timer_unit (
    input  wire         core_clk,
    input  wire         rst_n,
    input  wire         regSel,
    input  wire         regWr,
    input  wire         regRd,
    input  wire [4:0]   regAddr,
    input  wire [7:0]   regWdata,
    output logic [7:0]  regRdata,
    output logic [1:0]  intervalTimerIrqFlags,
    output logic        rateClkOut,
    output logic        kbdSampleEn,
    output logic        kbdBitEn
);
    // Register port qualifiers
    logic        wrStb;           // Write strobe for a selected access
    logic        rdStb;           // Read strobe for a selected access
    logic        inChBlock;       // Address falls in the channel block
    logic [1:0]  chIdx;           // Addressed channel
    logic [6:0]  chOfs;           // Byte offset inside a channel

    // Tick divider state
    logic [1:0]  tickCnt_r;       // Divider phase
    logic        tick;            // One-cycle step enable

    // Channel event pulses and output latches collected from the channels
    logic [3:0]  uflowVec;        // Underflow pulse per channel
    logic [15:0] snapVec [4];     // Output latch per channel

    // Derived outputs
    logic [1:0]  irqFlags_r;      // Latched interval flags
    logic        rateClk_r;       // Rate clock pin level
    logic [3:0]  kbdDiv_r;        // Sample to bit divider
    logic        kbdPhase_r;      // Channel 3 link clock level, toggled per underflow
    logic [7:0]  rdata_r;         // Registered read data
    logic [7:0]  rdata_nxt;       // Read data about to be captured

    // Word compare of a byte offset against the word index bus
    function automatic logic hitOfs(input logic [4:0] idx, input logic [6:0] ofs);
        hitOfs = (idx == ofs[6:2]);
    endfunction : hitOfs

    // Channel block decode from the word index
    function automatic logic [1:0] chOf(input logic [4:0] idx);
        logic [6:0] rel;
        rel = {idx, 2'b00} - qrt_pkg::CH_BASE_OFS;
        chOf = rel[5:4];
    endfunction : chOf

    // Offset of an access within its channel
    function automatic logic [6:0] ofsOf(input logic [4:0] idx);
        ofsOf = {3'b000, idx[1:0], 2'b00};
    endfunction : ofsOf

    assign wrStb     = regSel && regWr;
    assign rdStb     = regSel && regRd;
    // Channel block spans four strides above its base
    assign inChBlock = ({regAddr, 2'b00} >= qrt_pkg::CH_BASE_OFS);
    assign chIdx     = chOf(regAddr);
    assign chOfs     = ofsOf(regAddr);

    // Divider: one tick every four core clocks, shared by all channels
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tickCnt_r <= 2'h0;
        end else if (tickCnt_r == qrt_pkg::TICK_LAST) begin
            tickCnt_r <= 2'h0;
        end else begin
            tickCnt_r <= tickCnt_r + 2'h1;
        end
    end

    assign tick = (tickCnt_r == qrt_pkg::TICK_LAST); // RULE_03

    // Four identical channels, each behind its own carrier
    qrt_chan_if chIf [4] ();

    genvar g;
    generate
        for (g = 0; g < qrt_pkg::NUM_CH; g++) begin : gCh
            // Per-channel write decode; only one channel is hit at a time
            logic mine;
            assign mine = wrStb && inChBlock && (chIdx == 2'(g));

            assign chIf[g].tick   = tick;
            assign chIf[g].wdata  = regWdata;
            assign chIf[g].wrLow  = mine && (chOfs == qrt_pkg::CH_LOW_OFS);  // RULE_07
            assign chIf[g].wrHigh = mine && (chOfs == qrt_pkg::CH_HIGH_OFS); // RULE_07
            assign chIf[g].go     = mine && (chOfs == qrt_pkg::CH_GO_OFS);   // RULE_08
            assign chIf[g].snap   = mine && (chOfs == qrt_pkg::CH_SNAP_OFS); // RULE_09
            assign uflowVec[g]    = chIf[g].underflow;
            assign snapVec[g]     = chIf[g].snapVal;

            // Identical counters keep no shared state
            qrt_channel uChan (
                .core_clk (core_clk),
                .rst_n    (rst_n),
                .bus      (chIf[g])
            ); // RULE_01 RULE_02
        end
    endgenerate

    // Interval flags: a same-cycle underflow beats a clear, so no event is lost
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irqFlags_r <= qrt_pkg::FLAG_RST;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (uflowVec[i]) begin
                    irqFlags_r[i] <= 1'b1; // RULE_11
                end else if (wrStb && hitOfs(regAddr, qrt_pkg::IRQ_CLEAR_OFS)
                             && regWdata[i]) begin
                    // Several flags may clear in one write
                    irqFlags_r[i] <= 1'b0; // RULE_12
                end
            end
        end
    end

    assign intervalTimerIrqFlags = irqFlags_r;

    // Rate pin: toggle per channel 2 underflow gives half the event rate
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rateClk_r <= 1'b0;
        end else if (uflowVec[2]) begin
            rateClk_r <= ~rateClk_r; // RULE_14 RULE_18
        end
    end

    assign rateClkOut = rateClk_r;

    // Keyboard link clock: channel 3 toggles it like the rate pin does
    // Two underflows per clock period keep the sample rate at half the event rate
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            kbdPhase_r <= 1'b0;
        end else if (uflowVec[3]) begin
            kbdPhase_r <= ~kbdPhase_r; // RULE_15
        end
    end

    // Rising edge of the link clock is the sixteen-times sample enable
    assign kbdSampleEn = uflowVec[3] && !kbdPhase_r; // RULE_17

    // Bit enable every sixteenth sample; the divider phase runs free from reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            kbdDiv_r <= 4'h0;
        end else if (kbdSampleEn) begin
            kbdDiv_r <= (kbdDiv_r == qrt_pkg::KBD_LAST) ? 4'h0 : kbdDiv_r + 4'h1;
        end
    end

    assign kbdBitEn = kbdSampleEn && (kbdDiv_r == qrt_pkg::KBD_LAST); // RULE_15

    // Read mux; write-only and unmapped words read as zero
    always_comb begin
        rdata_nxt = qrt_pkg::RDATA_RST;
        if (hitOfs(regAddr, qrt_pkg::IRQ_STATUS_A_OFS)) begin
            rdata_nxt[qrt_pkg::IRQ_TM0_BIT] = irqFlags_r[0];
            rdata_nxt[qrt_pkg::IRQ_TM1_BIT] = irqFlags_r[1];
        end else if (inChBlock && chOfs == qrt_pkg::CH_LOW_OFS) begin
            rdata_nxt = snapVec[chIdx][7:0]; // RULE_10
        end else if (inChBlock && chOfs == qrt_pkg::CH_HIGH_OFS) begin
            rdata_nxt = snapVec[chIdx][15:8]; // RULE_10
        end
    end

    // Read data from a flop, held until the next read
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= qrt_pkg::RDATA_RST;
        end else if (rdStb) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign regRdata = rdata_r;
endmodule : qrt_timer_unit

// ### src/qrt_pkg.sv
// Shared constants of the quad reload timer unit
package qrt_pkg;
    // Datapath widths
    localparam int CNT_W          = 16;            // Counter and latch width
    localparam int BYTE_W         = 8;             // Register data width
    localparam int ADDR_W         = 5;             // Word index, byte address bits 6:2
    localparam int NUM_CH         = 4;             // Counter channels

    // Tick divider: counters step at the reference clock divided by four
    localparam int TICK_DIV       = 4;
    localparam logic [1:0] TICK_LAST = 2'(TICK_DIV - 1);

    // Keyboard link oversampling: bit rate is the sample rate over sixteen
    localparam int KBD_OVERSAMPLE = 16;
    localparam logic [3:0] KBD_LAST = 4'(KBD_OVERSAMPLE - 1);

    // Byte addresses of the interrupt registers
    localparam logic [6:0] IRQ_STATUS_A_OFS = 7'h10;   // Read: latched flags
    localparam logic [6:0] IRQ_CLEAR_OFS    = 7'h14;   // Write ones to clear

    // Byte addresses of the channel block; channel n adds n * CH_STRIDE
    localparam logic [6:0] CH_BASE_OFS      = 7'h40;
    localparam logic [6:0] CH_STRIDE        = 7'h10;
    localparam logic [6:0] CH_LOW_OFS       = 7'h00;   // Write reload low, read snapshot low
    localparam logic [6:0] CH_HIGH_OFS      = 7'h04;   // Write reload high, read snapshot high
    localparam logic [6:0] CH_GO_OFS        = 7'h08;   // Write: reload trigger
    localparam logic [6:0] CH_SNAP_OFS      = 7'h0c;   // Write: snapshot command

    // Flag positions in the interrupt status and clear registers
    localparam int IRQ_TM0_BIT    = 0;
    localparam int IRQ_TM1_BIT    = 1;

    // Reset values
    localparam logic [15:0] CNT_RST   = 16'h0000;
    localparam logic [7:0]  RDATA_RST = 8'h00;
    localparam logic [1:0]  FLAG_RST  = 2'h0;
endpackage : qrt_pkg

// ### src/qrt_chan_if.sv
`timescale 1ns/100ps
// Control and status of one counter channel
interface qrt_chan_if;
    logic        tick;      // Shared divided tick
    logic        wrLow;     // Write reload low byte
    logic        wrHigh;    // Write reload high byte
    logic        go;        // Reload trigger write
    logic        snap;      // Snapshot command write
    logic [7:0]  wdata;     // Write data byte
    logic [15:0] snapVal;   // Output latch
    logic        underflow; // One-cycle event pulse

    modport ctl  (output tick, wrLow, wrHigh, go, snap, wdata, input snapVal, underflow);
    modport chan (input tick, wrLow, wrHigh, go, snap, wdata, output snapVal, underflow);
endinterface : qrt_chan_if

// ### src/qrt_channel.sv
`timescale 1ns/100ps
// One reloading down-counter with input and output latches
module qrt_channel (
    input wire         core_clk,
    input wire         rst_n,
    qrt_chan_if.chan   bus
);
    logic [15:0] reload_r;  // Input latch
    logic [15:0] count_r;   // Down counter
    logic [15:0] snap_r;    // Output latch
    logic        stall_r;   // Extra tick owed after a colliding trigger
    logic        atZero;    // Counter sits at zero
    logic        uflow;     // Reload on this tick

    assign atZero = (count_r == 16'h0000);
    // Zero reload keeps the counter at zero, so it fires every tick
    assign uflow  = bus.tick && atZero && !stall_r; // RULE_04 RULE_05
    assign bus.underflow = uflow;
    assign bus.snapVal   = snap_r;

    // Input latch, written a byte at a time
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reload_r <= qrt_pkg::CNT_RST;
        end else begin
            if (bus.wrLow) begin
                reload_r[7:0] <= bus.wdata; // RULE_07
            end
            if (bus.wrHigh) begin
                reload_r[15:8] <= bus.wdata; // RULE_07
            end
        end
    end

    // Down counter: trigger write beats the tick
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= qrt_pkg::CNT_RST;
        end else if (bus.go) begin
            count_r <= reload_r; // RULE_08
        end else if (bus.tick && !stall_r) begin
            // Free running, gated only by the tick and the owed stall
            count_r <= atZero ? reload_r : count_r - 16'h0001; // RULE_03 RULE_04
        end
    end

    // A trigger colliding with an underflow costs one more tick
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stall_r <= 1'b0;
        end else if (bus.go && uflow) begin
            stall_r <= 1'b1; // RULE_06
        end else if (bus.tick) begin
            stall_r <= 1'b0; // RULE_06
        end
    end

    // Output latch holds until the next snapshot command
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            snap_r <= qrt_pkg::CNT_RST;
        end else if (bus.snap) begin
            snap_r <= count_r; // RULE_09 RULE_19
        end
    end
endmodule : qrt_channel

// ### sim/qrt_timer_unit_sva.sv
`timescale 1ns/100ps
// Port-level checker for the quad reload timer unit
module qrt_timer_unit_chk (
    input wire       core_clk,
    input wire       rst_n,
    input wire       regSel,
    input wire       regWr,
    input wire       regRd,
    input wire [4:0] regAddr,
    input wire [7:0] regWdata,
    input wire [7:0] regRdata,
    input wire [1:0] intervalTimerIrqFlags,
    input wire       rateClkOut,
    input wire       kbdSampleEn,
    input wire       kbdBitEn
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire       rdTake  = regSel && regRd;  // Read taken this edge
    wire [1:0] clrMask = (regSel && regWr && regAddr == 5'(qrt_pkg::IRQ_CLEAR_OFS >> 2))
                       ? regWdata[1:0] : 2'h0;  // Flags a clear write may drop
    logic [3:0] smpCnt_r;   // Samples since last bit enable
    logic       seenBit_r;  // Bit phase is free running, so wait for one first
    // Sample counter between bit enables
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            smpCnt_r  <= 4'h0;
            seenBit_r <= 1'b0;
        end else if (kbdBitEn) begin
            smpCnt_r  <= 4'h0;
            seenBit_r <= 1'b1;
        end else if (kbdSampleEn) begin
            smpCnt_r  <= smpCnt_r + 4'h1;
        end
    end
    AST_KBD_BIT_WITH_SAMPLE: assert property (kbdBitEn |-> kbdSampleEn)
        else $error("bit enable without sample enable");
    AST_KBD_SAMPLE_GAP: assert property (kbdSampleEn |=> !kbdSampleEn [*3])
        else $error("sample enables closer than one tick");
    AST_RATE_GAP: assert property ($changed(rateClkOut) |=> $stable(rateClkOut) [*3])
        else $error("rate pin toggled faster than one tick");
    AST_KBD_BIT_SPACING: assert property (kbdBitEn && seenBit_r |-> smpCnt_r == 4'hf)
        else $error("bit enable not every sixteenth sample");
    AST_FLAG_CLEAR_ONLY: assert property (
        (~intervalTimerIrqFlags & $past(intervalTimerIrqFlags) & ~$past(clrMask)) == 2'h0)
        else $error("flag dropped without a clear write");
    AST_RDATA_HOLD: assert property (!$past(rdTake) && !$past(rdTake, 2) |-> $stable(regRdata))
        else $error("read data moved without a read");
    AST_UNMAPPED_READ: assert property (rdTake && regAddr == 5'h00 |-> ##1 regRdata == 8'h00)
        else $error("unmapped read not zero");
    AST_WO_READ: assert property (rdTake && regAddr[4] && regAddr[1] |-> ##1 regRdata == 8'h00)
        else $error("write-only channel word read not zero");
endmodule : qrt_timer_unit_chk
bind qrt_timer_unit qrt_timer_unit_chk qrt_timer_unit_chk_inst (.core_clk(core_clk),
    .rst_n(rst_n), .regSel(regSel), .regWr(regWr), .regRd(regRd), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .intervalTimerIrqFlags(intervalTimerIrqFlags),
    .rateClkOut(rateClkOut), .kbdSampleEn(kbdSampleEn), .kbdBitEn(kbdBitEn));

// ### sim/qrt_host_model.sv
`timescale 1ns/100ps
// Host side of the register bus; every task is entered at a rising edge
module qrt_host_model (
    input  wire        core_clk,
    output logic       regSel,
    output logic       regWr,
    output logic       regRd,
    output logic [4:0] regAddr,
    output logic [7:0] regWdata,
    input  wire  [7:0] regRdata
);
    // Idle bus at time zero
    initial begin
        regSel   = 1'b0;
        regWr    = 1'b0;
        regRd    = 1'b0;
        regAddr  = 5'h00;
        regWdata = 8'h5a;
    end
    // Word index of a channel register
    function automatic logic [4:0] word(input int ch, input logic [6:0] ofs);
        return 5'((qrt_pkg::CH_BASE_OFS + qrt_pkg::CH_STRIDE * 7'(ch) + ofs) >> 2);
    endfunction : word
    // Write held one cycle, taken at the edge it returns on
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        regSel   <= 1'b1;
        regWr    <= 1'b1;
        regRd    <= 1'b0;
        regAddr  <= a;
        regWdata <= d;
        @(posedge core_clk);
    endtask : wr
    // Released data flips so a stale byte is never mistaken for fresh
    task automatic idle(input int n);
        regSel   <= 1'b0;
        regWr    <= 1'b0;
        regRd    <= 1'b0;
        regWdata <= ~regWdata;
        repeat (n) @(posedge core_clk);
    endtask : idle
    // Read; data is sampled one and a half cycles after the taking edge
    task automatic rd(input logic [4:0] a, output logic [7:0] q);
        regSel  <= 1'b1;
        regWr   <= 1'b0;
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        idle(1);
        @(negedge core_clk);
        q = regRdata;
        @(posedge core_clk);
    endtask : rd
    // Full programming before any value is trusted; reload sets the interval
    task automatic prog(input int ch, input logic [15:0] r);
        wr(word(ch, qrt_pkg::CH_LOW_OFS), r[7:0]);
        wr(word(ch, qrt_pkg::CH_HIGH_OFS), r[15:8]);
        wr(word(ch, qrt_pkg::CH_GO_OFS), r[7:0] ^ 8'h3c);
    endtask : prog
    // Snapshot then both bytes, with a gap so the counter moves between reads
    task automatic snap16(input int ch, output logic [15:0] v);
        wr(word(ch, qrt_pkg::CH_SNAP_OFS), 8'ha5);
        rd(word(ch, qrt_pkg::CH_LOW_OFS), v[7:0]);
        idle(5);
        rd(word(ch, qrt_pkg::CH_HIGH_OFS), v[15:8]);
    endtask : snap16
endmodule : qrt_host_model

// ### sim/tb_qrt_timer_unit.sv
`timescale 1ns/100ps
// Self-checking bench for the quad reload timer unit
module tb_qrt_timer_unit;
    logic        core_clk;     // 250 MHz clock
    logic        rst_n;        // Async reset, active low
    wire         regSel, regWr, regRd;
    wire  [4:0]  regAddr;
    wire  [7:0]  regWdata, regRdata;
    wire  [1:0]  irqFlags;
    wire         rateClk, kbdSmp, kbdBit;
    int          failures, check_count;
    int          seed = 32'hb1fc9aeb;
    int          rateCnt, rateGap, smpCnt, smpGap, bitCnt, bitGap;  // Event spacing meters
    logic        ratePrev;
    logic [15:0] rv, v;
    logic [7:0]  q;
    int          k;
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    qrt_host_model qrt_host_model_inst (.core_clk(core_clk), .regSel(regSel), .regWr(regWr),
        .regRd(regRd), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata));
    qrt_timer_unit qrt_timer_unit_inst (.core_clk(core_clk), .rst_n(rst_n), .regSel(regSel),
        .regWr(regWr), .regRd(regRd), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata(regRdata), .intervalTimerIrqFlags(irqFlags), .rateClkOut(rateClk),
        .kbdSampleEn(kbdSmp), .kbdBitEn(kbdBit));
    // Cycles between successive toggles and pulses
    always @(posedge core_clk) begin
        ratePrev <= rateClk;
        rateCnt  <= (rateClk !== ratePrev) ? 1 : rateCnt + 1;
        rateGap  <= (rateClk !== ratePrev) ? rateCnt : rateGap;
        smpCnt   <= kbdSmp ? 1 : smpCnt + 1;
        smpGap   <= kbdSmp ? smpCnt : smpGap;
        bitCnt   <= kbdBit ? 1 : bitCnt + 1;
        bitGap   <= kbdBit ? bitCnt : bitGap;
    end
    // Clock cycles for mult underflow periods of reload r
    function automatic int exp_gap(input logic [15:0] r, input int mult);
        return qrt_pkg::TICK_DIV * (int'(r) + 1) * mult;
    endfunction : exp_gap
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test();
        if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    // Hang guard, well past the expected run
    initial begin
        #200000;
        failures++;
        finish_test();
    end
    initial begin
        rst_n = 1'b0;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        qrt_host_model_inst.idle(8);
        check(16'(irqFlags), 16'h0003);
        // Trigger lands on a channel 0 underflow: one tick is lost
        rv = 16'h0100 + 16'($unsigned($random(seed)) % 32'h7f00);
        k  = 2 + $unsigned($random(seed)) % 7;
        do @(negedge core_clk); while (kbdSmp !== 1'b1);
        @(posedge core_clk);
        qrt_host_model_inst.idle(1);
        qrt_host_model_inst.prog(0, rv);
        qrt_host_model_inst.idle(4 * k);
        qrt_host_model_inst.snap16(0, v);
        check(v, rv - 16'(k - 1));
        // Plain trigger with random data, then k ticks
        qrt_host_model_inst.wr(qrt_host_model_inst.word(0, qrt_pkg::CH_GO_OFS), 8'($random(seed)));
        qrt_host_model_inst.idle(4 * k);
        qrt_host_model_inst.snap16(0, v);
        check(v, rv - 16'(k));
        // Clear one flag, then both at once
        qrt_host_model_inst.wr(5'(qrt_pkg::IRQ_CLEAR_OFS >> 2), 8'h01);
        qrt_host_model_inst.rd(5'(qrt_pkg::IRQ_STATUS_A_OFS >> 2), q);
        check(16'(q), 16'h0002);
        qrt_host_model_inst.prog(1, rv);
        qrt_host_model_inst.wr(5'(qrt_pkg::IRQ_CLEAR_OFS >> 2), 8'h03);
        qrt_host_model_inst.rd(5'(qrt_pkg::IRQ_STATUS_A_OFS >> 2), q);
        check(16'(q), 16'h0000);
        k = 2 + $unsigned($random(seed)) % 5;
        qrt_host_model_inst.prog(1, 16'(k));
        qrt_host_model_inst.idle(exp_gap(16'(k + 1), 1) + 4);
        check(16'(irqFlags), 16'h0002);
        // Unmapped and write-only words read as zero
        qrt_host_model_inst.rd(5'h00, q);
        check(16'(q), 16'h0000);
        qrt_host_model_inst.rd(qrt_host_model_inst.word(3, qrt_pkg::CH_SNAP_OFS), q);
        check(16'(q), 16'h0000);
        // Rate pin and keyboard enables, reload of one then random
        for (int i = 0; i < 3; i++) begin
            rv = (i == 0) ? 16'h0001 : 16'h0002 + 16'($unsigned($random(seed)) % 8);
            qrt_host_model_inst.prog(2, rv);
            qrt_host_model_inst.prog(3, rv);
            // Long enough for two bit enables after the new reload settles
            qrt_host_model_inst.idle(exp_gap(rv, 72));
            check(16'(rateGap), 16'(exp_gap(rv, 1)));
            check(16'(smpGap), 16'(exp_gap(rv, 2)));
            check(16'(bitGap), 16'(exp_gap(rv, 32)));
        end
        finish_test();
    end
endmodule : tb_qrt_timer_unit
